// *** hw/sbs_cfg.svh ***
// constants for the sync burst sram core and its controller
`ifndef SBS_CFG_SVH
`define SBS_CFG_SVH
`define SBS_ADDR_W 10
`define SBS_LANES 4
`define SBS_LANE_W 8
`define SBS_BEAT_W 2
`define SBS_CTRL_AW 5
`define SBS_OFS_CTRL 5'h00
`define SBS_OFS_ADDR 5'h04
`define SBS_OFS_WDATA 5'h08
`define SBS_OFS_STATUS 5'h0C
`define SBS_OFS_RDATA 5'h10
`define SBS_CTRL_GO 0
`define SBS_CTRL_WRITE 1
`define SBS_CTRL_BURST 2
`define SBS_CTRL_LANES_LSB 4
`define SBS_CTRL_MODE_LSB 8
`define SBS_RD_LAT_PIPE 4'h3
`define SBS_RD_LAT_FLOW 4'h2
`endif

// *** hw/sbs_pkg.sv ***
// types shared by both ends of the sync burst sram link
`default_nettype none
`include "sbs_cfg.svh"
package sbs_pkg;
  typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
  typedef logic [`SBS_LANES*`SBS_LANE_W-1:0] sbs_data_t;
  typedef logic [`SBS_LANES-1:0] sbs_lane_t;
  typedef enum logic [2:0] {
    SBS_IDLE = 3'h1,
    SBS_BUSY = 3'h2,
    SBS_WAIT = 3'h4
  } sbs_state_e;
endpackage
`default_nettype wire

// *** hw/sbs_if.sv ***
// memory-side pin bundle between controller and burst sram core
`timescale 1ns/100ps
`default_nettype none
interface sbs_if;
  import sbs_pkg::*;
  sbs_addr_t addr;
  logic chip_select_first_low_n;
  logic chip_select_high;
  logic chip_select_third_low_n;
  logic processor_addr_strobe_n;
  logic controller_addr_strobe_n;
  logic burst_step_n;
  logic all_lanes_write_n;
  logic lane_write_gate_n;
  sbs_lane_t lane_write_select_n;
  logic out_enable_n;
  logic sleep_request;
  logic linear_order_select_n;
  logic flowthrough_select_n;
  logic single_deselect_select;
  logic odd_parity_select;
  sbs_data_t ctl_dq_out;
  logic ctl_dq_oe_n;
  sbs_data_t mem_dq_out;
  logic mem_dq_oe_n;
  sbs_lane_t parity_error;
  // resolved shared data bus; a released bus shows the inverse of the core's mem_dq_out output data
  sbs_data_t dq;
  assign dq = !ctl_dq_oe_n ? ctl_dq_out : !mem_dq_oe_n ? mem_dq_out : ~mem_dq_out;
  modport ctl (
    output addr, chip_select_first_low_n, chip_select_high, chip_select_third_low_n,
    output processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n,
    output all_lanes_write_n, lane_write_gate_n, lane_write_select_n,
    output out_enable_n, sleep_request, linear_order_select_n,
    output flowthrough_select_n, single_deselect_select, odd_parity_select,
    output ctl_dq_out, ctl_dq_oe_n,
    input mem_dq_out, mem_dq_oe_n, parity_error, dq
  );
  modport mem (
    input addr, chip_select_first_low_n, chip_select_high, chip_select_third_low_n,
    input processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n,
    input all_lanes_write_n, lane_write_gate_n, lane_write_select_n,
    input out_enable_n, sleep_request, linear_order_select_n,
    input flowthrough_select_n, single_deselect_select, odd_parity_select,
    input ctl_dq_out, ctl_dq_oe_n,
    output mem_dq_out, mem_dq_oe_n, parity_error
  );
endinterface
`default_nettype wire

// *** hw/sbs_mem.sv ***
// sync burst sram core: memory array, burst counter, read pipeline
//
// Behaviour
// - sample all synchronous inputs on rising clock
// - output enable and sleep act asynchronously
// - either address strobe starts a burst
// - two-bit burst counter makes low address
// - burst counter steps only when advance asserted
// - linear or interleaved order by mode pin
// - unconnected modes: scd, interleaved, pipelined
// - fresh address accepted every cycle
// - flow-through low bypasses output register
// - flow-through high adds output register stage
// - single deselect: outputs off one stage early
// - dual deselect: outputs off after second edge
// - deselect mode chosen by mode pin
// - byte lanes written when lane and gate
// - global write writes all lanes
// - sleep request or stopped clock retains data
// - writes self-timed, no extra cycles
// - read parity checked, even or odd selectable
// - strobes and advance active low; controller ties processor strobe and advance high
// - chip enables: first/third low, second high
// - write controls are active low
// - low address bits preset burst counter
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "sbs_cfg.svh"
module sbs_mem #(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int LANES = `SBS_LANES,
  parameter int LANE_W = `SBS_LANE_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // memory pins
  sbs_if.mem pins,
  // status
  output logic asleep
);
  import sbs_pkg::*;
  localparam int DW = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  logic [DW-1:0] mem_q [DEPTH];
  // mode pins; an undriven (x/z) mode pin falls to the default
  wire scd_mode = (pins.single_deselect_select !== 1'b0);
  wire linear_mode = (pins.linear_order_select_n === 1'b0);
  wire pipe_mode = (pins.flowthrough_select_n !== 1'b0);
  // chip select and strobe decode
  wire selected = !pins.chip_select_first_low_n && pins.chip_select_high &&
                  !pins.chip_select_third_low_n;
  wire sleep_now = pins.sleep_request;
  wire strobe_p = !pins.processor_addr_strobe_n;
  wire strobe_c = !pins.controller_addr_strobe_n;
  // processor strobe ignored when first chip enable is high
  wire load = !sleep_now && ((strobe_p && !pins.chip_select_first_low_n) || strobe_c);
  wire deselect = load && !selected;
  wire advance = !sleep_now && !load && !pins.burst_step_n;
  // burst counter and stored base
  logic [ADDR_W-1:0] base_q;
  logic active_q;
  logic wr_pend_q;
  wire [1:0] low_now;
  // burst counter makes the low address of later beats
  sbs_burst_ctr #(
    .BEAT_W(`SBS_BEAT_W)
  ) sbs_burst_ctr_i (
    .clock(clock),
    .resetn(resetn),
    .load(load),
    .advance(advance),
    .linear_mode(linear_mode),
    .preset(pins.addr[1:0]),
    .low_addr(low_now)
  );
  wire [ADDR_W-1:0] cur_addr = load ? pins.addr : {base_q[ADDR_W-1:2], low_now};
  // write decode; processor strobe cycle is always a read
  wire wr_cycle = !sleep_now && (load ? (strobe_c && selected) : active_q) &&
                  !(load && strobe_p && !pins.chip_select_first_low_n);
  wire glob_wr = !pins.all_lanes_write_n;
  wire [LANES-1:0] lane_en = glob_wr ? {LANES{1'b1}} :
    ({LANES{!pins.lane_write_gate_n}} & ~pins.lane_write_select_n);
  wire any_wr = wr_cycle && (glob_wr || |lane_en);
  wire rd_cycle = !sleep_now && !any_wr && (load ? selected : (active_q && advance));
  // address and burst state, sampled on the rising edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      base_q <= '0;
      active_q <= 1'b0;
    end else if (load) begin
      base_q <= pins.addr;
      active_q <= selected;
    end
  end
  // byte-lane writes complete in the capture cycle
  always_ff @(posedge clock) begin
    for (int i = 0; i < LANES; i++) begin
      if (any_wr && lane_en[i]) begin
        mem_q[cur_addr][i*LANE_W +: LANE_W] <= pins.ctl_dq_out[i*LANE_W +: LANE_W];
      end
    end
  end
  // read pipeline: stage 1 array data, stage 2 output register
  logic [DW-1:0] rd1_q;
  logic [DW-1:0] rd2_q;
  logic rv1_q;
  logic rv2_q;
  logic ds1_q;
  logic ds2_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd1_q <= '0;
      rd2_q <= '0;
      rv1_q <= 1'b0;
      rv2_q <= 1'b0;
      ds1_q <= 1'b0;
      ds2_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else begin
      rd1_q <= mem_q[cur_addr];
      rd2_q <= rd1_q;
      rv1_q <= rd_cycle;
      rv2_q <= rv1_q;
      ds1_q <= deselect || any_wr;
      ds2_q <= ds1_q;
      wr_pend_q <= any_wr;
    end
  end
  // output data and enable by mode
  wire [DW-1:0] rd_data = pipe_mode ? rd2_q : rd1_q;
  wire rd_valid = pipe_mode ? rv2_q : rv1_q;
  // scd cuts outputs as soon as a deselect is captured
  wire ds_cut = scd_mode ? ds1_q : ds2_q;
  wire drive = rd_valid && !(pipe_mode && ds_cut && !rv1_q) && !wr_pend_q;
  assign pins.mem_dq_out = rd_data;
  assign pins.mem_dq_oe_n = !(drive && !pins.out_enable_n && !sleep_now);
  assign asleep = sleep_now;
  // per-lane parity of read data against selected polarity
  wire [LANES-1:0] par_err;
  genvar g;
  for (g = 0; g < LANES; g++) begin : g_par
    sbs_lane_par #(
      .LANE_W(LANE_W)
    ) sbs_lane_par_i (
      .lane_data(rd_data[g*LANE_W +: LANE_W]),
      .valid(rd_valid),
      .odd_select(pins.odd_parity_select),
      .lane_err(par_err[g])
    );
  end
  // flags are only meaningful while read data stands
  assign pins.parity_error = par_err;
endmodule

// two-bit burst counter: preset from low address bits, steps on advance
module sbs_burst_ctr #(
  parameter int BEAT_W = `SBS_BEAT_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // load and step controls
  input wire logic load,
  input wire logic advance,
  input wire logic linear_mode,
  // preset from the low address bits
  input wire logic [BEAT_W-1:0] preset,
  // low address of the current beat
  output logic [BEAT_W-1:0] low_addr
);
  import sbs_pkg::*;
  logic [BEAT_W-1:0] ofs_q;
  logic [BEAT_W-1:0] beat_q;
  // beat count wraps at the burst length
  wire [BEAT_W-1:0] beat_d = beat_q + BEAT_W'(1);
  // offset and beat count, preset by a strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ofs_q <= '0;
      beat_q <= '0;
    end else if (load) begin
      ofs_q <= preset;
      beat_q <= '0;
    end else if (advance) begin
      beat_q <= beat_d;
    end
  end
  // linear adds the beat, interleaved xors it
  assign low_addr = linear_mode ? BEAT_W'(ofs_q + beat_q) : (ofs_q ^ beat_q);
endmodule

// one byte lane's read parity against the selected polarity
module sbs_lane_par #(
  parameter int LANE_W = `SBS_LANE_W
) (
  // lane read data and its valid
  input wire logic [LANE_W-1:0] lane_data,
  input wire logic valid,
  // parity polarity, high for odd
  input wire logic odd_select,
  // lane error flag
  output logic lane_err
);
  import sbs_pkg::*;
  // even parity expected while odd select is low
  assign lane_err = valid && ((^lane_data) ^ odd_select);
endmodule
`default_nettype wire

// *** hw/sbs_ctl.sv ***
// controller end: axi4-lite registers drive single sram reads and writes
`timescale 1ns/100ps
`default_nettype none
`include "sbs_cfg.svh"
module sbs_ctl (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // axi4-lite slave
  input wire logic [`SBS_CTRL_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SBS_CTRL_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory pins
  sbs_if.ctl pins
);
  import sbs_pkg::*;
  logic [31:0] ctrl_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [3:0] perr_q;
  sbs_state_e state_q;
  logic [3:0] cnt_q;
  logic aw_q;
  logic w_q;
  logic [`SBS_CTRL_AW-1:0] awa_q;
  logic [31:0] wd_q;
  // write channel capture in either order
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  wire aw_have = aw_q || s_axi_awvalid;
  wire w_have = w_q || s_axi_wvalid;
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire [`SBS_CTRL_AW-1:0] wa = aw_q ? awa_q : s_axi_awaddr;
  wire [31:0] wd = w_q ? wd_q : s_axi_wdata;
  wire go = wr_fire && wa == `SBS_OFS_CTRL && wd[`SBS_CTRL_GO] && state_q == SBS_IDLE;
  wire wr_ok = wa == `SBS_OFS_CTRL || wa == `SBS_OFS_ADDR || wa == `SBS_OFS_WDATA;
  // write channel registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) awa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
      aw_q <= wr_fire ? 1'b0 : aw_have;
      w_q <= wr_fire ? 1'b0 : w_have;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // register stores
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 32'h0000_0000;
      addr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (wa == `SBS_OFS_CTRL) ctrl_q <= {wd[31:1], 1'b0};
      if (wa == `SBS_OFS_ADDR) addr_q <= wd;
      if (wa == `SBS_OFS_WDATA) wdata_q <= wd;
    end
  end
  // read channel
  wire busy = state_q != SBS_IDLE;
  wire [31:0] status = {24'h0, perr_q, 3'h0, busy};
  wire [31:0] rsel = s_axi_araddr == `SBS_OFS_CTRL ? ctrl_q :
    s_axi_araddr == `SBS_OFS_ADDR ? addr_q :
    s_axi_araddr == `SBS_OFS_WDATA ? wdata_q :
    s_axi_araddr == `SBS_OFS_STATUS ? status :
    s_axi_araddr == `SBS_OFS_RDATA ? rdata_q : 32'h0;
  wire rd_ok = s_axi_araddr <= `SBS_OFS_RDATA && s_axi_araddr[1:0] == 2'h0;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rsel : 32'h0;
      s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // one access: strobe cycle, then for a read only, wait for read data
  wire is_wr = ctrl_q[`SBS_CTRL_WRITE];
  wire [3:0] lat = ctrl_q[`SBS_CTRL_MODE_LSB+1] ? `SBS_RD_LAT_FLOW : `SBS_RD_LAT_PIPE;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= SBS_IDLE;
      cnt_q <= 4'h0;
      rdata_q <= 32'h0;
      perr_q <= 4'h0;
    end else begin
      case (state_q)
        SBS_IDLE: begin
          if (go) begin
            state_q <= SBS_BUSY;
            cnt_q <= 4'h0;
          end
        end
        SBS_BUSY: begin
          state_q <= is_wr ? SBS_IDLE : SBS_WAIT;
          cnt_q <= 4'h2; // edges since the strobe cycle, as seen at the next edge
        end
        SBS_WAIT: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == lat) begin
            rdata_q <= pins.dq;
            perr_q <= pins.parity_error;
            state_q <= SBS_IDLE;
          end
        end
        default: state_q <= SBS_IDLE;
      endcase
    end
  end
  // pin drive: strobe only in busy cycle, strobe and write controls active-low
  wire strobe = state_q == SBS_BUSY;
  assign pins.addr = addr_q[`SBS_ADDR_W-1:0];
  assign pins.chip_select_first_low_n = 1'b0;
  assign pins.chip_select_high = 1'b1;
  assign pins.chip_select_third_low_n = 1'b0;
  assign pins.processor_addr_strobe_n = 1'b1;
  assign pins.controller_addr_strobe_n = !strobe;
  assign pins.burst_step_n = 1'b1;
  assign pins.all_lanes_write_n = !(strobe && is_wr && ctrl_q[`SBS_CTRL_BURST]);
  assign pins.lane_write_gate_n = !(strobe && is_wr);
  assign pins.lane_write_select_n = ~ctrl_q[`SBS_CTRL_LANES_LSB +: 4];
  assign pins.out_enable_n = is_wr;
  assign pins.sleep_request = ctrl_q[`SBS_CTRL_MODE_LSB+4];
  assign pins.linear_order_select_n = !ctrl_q[`SBS_CTRL_MODE_LSB];
  assign pins.flowthrough_select_n = !ctrl_q[`SBS_CTRL_MODE_LSB+1];
  assign pins.single_deselect_select = !ctrl_q[`SBS_CTRL_MODE_LSB+2];
  assign pins.odd_parity_select = ctrl_q[`SBS_CTRL_MODE_LSB+3];
  assign pins.ctl_dq_out = wdata_q;
  assign pins.ctl_dq_oe_n = !(strobe && is_wr);
endmodule
`default_nettype wire

// *** verif/sbs_link_sva.sv ***
// assertions on the memory-side link between controller and core
`timescale 1ns/100ps
`default_nettype none
module sbs_link_sva (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // selects and strobes
  input wire logic chip_select_first_low_n,
  input wire logic chip_select_high,
  input wire logic chip_select_third_low_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_step_n,
  // write controls
  input wire logic all_lanes_write_n,
  input wire logic lane_write_gate_n,
  input wire sbs_pkg::sbs_lane_t lane_write_select_n,
  // async controls and modes
  input wire logic out_enable_n,
  input wire logic sleep_request,
  input wire logic flowthrough_select_n,
  input wire logic single_deselect_select,
  // data bus enables
  input wire logic ctl_dq_oe_n,
  input wire logic mem_dq_oe_n
);
  import sbs_pkg::*;
  // decoded commands seen at the pins
  wire logic sel = !chip_select_first_low_n && chip_select_high && !chip_select_third_low_n;
  wire logic wr = !all_lanes_write_n || (!lane_write_gate_n && !(&lane_write_select_n));
  wire logic cmd = sel && !controller_addr_strobe_n && !sleep_request;
  wire logic rd_cmd = cmd && !wr;
  wire logic wr_cmd = cmd && wr;
  wire logic idle = controller_addr_strobe_n && processor_addr_strobe_n && burst_step_n;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_oe_forces_off: assert property (out_enable_n |-> mem_dq_oe_n)
    else $error("memory drives bus with output enable off");
  a_flow_latency: assert property (rd_cmd && !flowthrough_select_n |-> ##1 (out_enable_n || !mem_dq_oe_n))
    else $error("flow-through read data not driven after one edge");
  a_pipe_latency: assert property (rd_cmd && flowthrough_select_n |-> ##2 (out_enable_n || !mem_dq_oe_n))
    else $error("pipelined read data not driven after two edges");
  a_scd_turn_off: assert property (rd_cmd && !flowthrough_select_n && single_deselect_select ##1 idle |-> ##1 mem_dq_oe_n)
    else $error("single deselect left outputs on");
  a_write_no_drive: assert property (wr_cmd |-> ##1 mem_dq_oe_n)
    else $error("memory drives bus after a write");
  a_write_data_on: assert property (wr_cmd |-> !ctl_dq_oe_n)
    else $error("write data not presented at capture edge");
  a_strobe_selects: assert property (!controller_addr_strobe_n |-> sel)
    else $error("strobe issued without chip selected");
  a_no_bus_clash: assert property (!ctl_dq_oe_n |-> mem_dq_oe_n)
    else $error("both ends drive the data bus");
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench: axi4-lite accesses through controller into the core
`timescale 1ns/100ps
`default_nettype none
`include "sbs_cfg.svh"
module testbench;
  import sbs_pkg::*;
  logic clock = 1'h0;
  logic resetn = 1'h0;
  logic [`SBS_CTRL_AW-1:0] s_axi_awaddr = 5'h00;
  logic [`SBS_CTRL_AW-1:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, asleep;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] s;
  logic [1:0] r;

  sbs_if link();
  sbs_ctl sbs_ctl_i (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins(link));
  sbs_mem sbs_mem_i (.clock, .resetn, .pins(link), .asleep);
  sbs_link_sva sbs_link_sva_i (.clock, .resetn,
    .chip_select_first_low_n(link.chip_select_first_low_n),
    .chip_select_high(link.chip_select_high),
    .chip_select_third_low_n(link.chip_select_third_low_n),
    .processor_addr_strobe_n(link.processor_addr_strobe_n),
    .controller_addr_strobe_n(link.controller_addr_strobe_n),
    .burst_step_n(link.burst_step_n), .all_lanes_write_n(link.all_lanes_write_n),
    .lane_write_gate_n(link.lane_write_gate_n), .lane_write_select_n(link.lane_write_select_n),
    .out_enable_n(link.out_enable_n), .sleep_request(link.sleep_request),
    .flowthrough_select_n(link.flowthrough_select_n),
    .single_deselect_select(link.single_deselect_select),
    .ctl_dq_oe_n(link.ctl_dq_oe_n), .mem_dq_oe_n(link.mem_dq_oe_n));

  // clock generator
  initial forever #2 clock = ~clock;

  // verdict and end of run
  task tally_and_finish;
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // compare a data word
  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare a status flag
  task cmp_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // axi4-lite write: address and data together, each released when taken
  task axi_wr(input logic [`SBS_CTRL_AW-1:0] a, input logic [31:0] d);
    bit aw, w, b;
    aw = 0; w = 0; b = 0;
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
    while (!b) begin
      @(posedge clock);
      if (!aw && s_axi_awready === 1'h1) begin aw = 1; s_axi_awvalid <= 1'h0; end
      if (!w && s_axi_wready === 1'h1) begin w = 1; s_axi_wvalid <= 1'h0; end
      if (s_axi_bvalid === 1'h1) begin b = 1; s_axi_bready <= 1'h0; end
    end
  endtask

  // axi4-lite read
  task axi_rd(input logic [`SBS_CTRL_AW-1:0] a, output logic [31:0] d, output logic [1:0] rs);
    bit ar, rv;
    ar = 0; rv = 0; d = 32'h0; rs = 2'h0;
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
    while (!rv) begin
      @(posedge clock);
      if (!ar && s_axi_arready === 1'h1) begin ar = 1; s_axi_arvalid <= 1'h0; end
      if (s_axi_rvalid === 1'h1) begin rv = 1; s_axi_rready <= 1'h0; d = s_axi_rdata; rs = s_axi_rresp; end
    end
  endtask

  // one memory access by register orders, polled until not busy
  task access(input logic [9:0] a, input logic [31:0] d, input logic [31:0] c);
    axi_wr(`SBS_OFS_ADDR, {22'h0, a});
    axi_wr(`SBS_OFS_WDATA, d);
    axi_wr(`SBS_OFS_CTRL, c | 32'h1);
    do begin
      axi_rd(`SBS_OFS_STATUS, s, r);
    end while (s[0] !== 1'h0);
  endtask

  // per-lane parity flags
  function automatic logic [3:0] par(input logic [31:0] d, input logic odd);
    for (int i = 0; i < 4; i++) par[i] = (^d[8*i +: 8]) ^ odd;
  endfunction

  // watchdog
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end

  // test sequence
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'h1;
    axi_rd(5'h14, s, r);
    cmp_word({30'h0, r}, 32'h2);
    cmp_word(s, 32'h0);
    // flow/pipe and single/dual deselect, all-lanes write with lane enables off
    for (int m = 0; m < 4; m++) begin
      access(10'h010 + 10'(m), 32'hA5A50000 + 32'(m), (32'(m) << 9) | 32'h6);
      access(10'h010 + 10'(m), 32'h0, 32'(m) << 9);
      axi_rd(`SBS_OFS_RDATA, s, r);
      cmp_word(s, 32'hA5A50000 + 32'(m));
    end
    // lanes 0 and 2 only at the top address
    access(10'h3FF, 32'h11223344, 32'h6);
    access(10'h3FF, 32'hFFFFFFFF, 32'h52);
    access(10'h3FF, 32'h0, 32'h0);
    axi_rd(`SBS_OFS_RDATA, s, r);
    cmp_word(s, 32'h11FF33FF);
    // read parity, even then odd
    access(10'h020, 32'h01030307, 32'h6);
    for (int o = 0; o < 2; o++) begin
      access(10'h020, 32'h0, 32'(o) << 11);
      axi_rd(`SBS_OFS_STATUS, s, r);
      cmp_word({28'h0, s[7:4]}, {28'h0, par(32'h01030307, o[0])});
    end
    // sleep and wake, data kept
    axi_wr(`SBS_OFS_CTRL, 32'h1000);
    @(posedge clock);
    cmp_flag(asleep, 1'h1);
    axi_wr(`SBS_OFS_CTRL, 32'h0);
    @(posedge clock);
    cmp_flag(asleep, 1'h0);
    access(10'h020, 32'h0, 32'h0);
    axi_rd(`SBS_OFS_RDATA, s, r);
    cmp_word(s, 32'h01030307);
    tally_and_finish();
  end
endmodule
`default_nettype wire
